// ==== verilog/epiv_pkg.sv ====
// Constants, register map and types for the external pin request and vectoring block.
// Assumes a 32-bit APB register bus and an 8-bit CPU core with a 16-bit address space.
package epiv_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int EPIV_NUM_VEC = 32;
  localparam int EPIV_VEC_AW = 6;
  localparam int EPIV_ADDR_W = 12;
  localparam int EPIV_DW = 8;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] EPIV_REG_PIN_CTRL = 12'h000;
  localparam logic [11:0] EPIV_REG_PENDING = 12'h004;
  localparam logic [11:0] EPIV_REG_WINNER = 12'h008;
  localparam logic [11:0] EPIV_REG_VEC_BASE = 12'h100;
  localparam logic [11:0] EPIV_REG_VEC_LAST = 12'h1fc;

  // ----------------------------------------------------------------------
  // Field positions of pin_request_status_control
  // ----------------------------------------------------------------------
  localparam int EPIV_BIT_ENABLE = 0;
  localparam int EPIV_BIT_POLARITY = 1;
  localparam int EPIV_BIT_MODE = 2;
  localparam int EPIV_BIT_PULL_OFF = 3;
  localparam int EPIV_BIT_IRQ_EN = 4;
  localparam int EPIV_BIT_ACK = 5;
  localparam int EPIV_BIT_FLAG = 6;
  localparam int EPIV_BIT_LEVEL = 7;
  localparam logic [4:0] EPIV_CTRL_RESET = 5'h00;

  // ----------------------------------------------------------------------
  // Vector space
  // ----------------------------------------------------------------------
  localparam logic [4:0] EPIV_PIN_VECTOR = 5'h03;
  localparam int EPIV_USER_VEC_LO = 24;
  localparam logic [15:0] EPIV_VEC_BASE_ADDR = 16'hffc0;
  localparam logic [2:0] EPIV_STACK_LAST = 3'h4;

  typedef enum {
    EPIV_ST_IDLE,
    EPIV_ST_PUSH,
    EPIV_ST_FETCH_HI,
    EPIV_ST_FETCH_LO,
    EPIV_ST_DONE
  } epiv_seq_e;

endpackage

// ==== verilog/epiv_vec_if.sv ====
// Interface between the vectoring logic and its vector table memory.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface epiv_vec_if;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;

  modport host (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ==== verilog/epiv_vec_mem.sv ====
// Vector table: 64 bytes, high byte of each handler at the even index.
// Assumes writes and reads on the same clock; read data is registered.
`timescale 1ns/1ps
module epiv_vec_mem #(
  parameter int DEPTH = 64
) (
  input wire logic clk,
  epiv_vec_if.mem bus
);

  logic [7:0] mem [DEPTH];

  // ----------------------------------------------------------------------
  // Storage and registered read, no reset so it maps onto RAM
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (bus.wr_en) begin
      mem[bus.wr_addr] <= bus.wr_data;
    end
    bus.rd_data <= mem[bus.rd_addr];
  end

endmodule

// ==== verilog/epiv_top.sv ====
// External request pin logic, priority selection and interrupt sequencing.
// Assumes an APB master on clk, a CPU that signals instruction boundaries,
// and peripheral request lines already gated by their local enables.
`timescale 1ns/1ps

module epiv_top
  import epiv_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [epiv_pkg::EPIV_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic pin_in,
  input wire logic stop_mode,
  output logic pull_up_en,
  output logic pull_down_en,
  output logic wake_req,
  output logic branch_pin_level,
  output logic branch_pin_valid,
  input wire logic [epiv_pkg::EPIV_NUM_VEC-1:0] src_req,
  output logic irq_to_cpu,
  input wire logic cpu_boundary,
  input wire logic cpu_i_mask,
  input wire logic [15:0] cpu_pc,
  input wire logic [7:0] cpu_x,
  input wire logic [7:0] cpu_a,
  input wire logic [7:0] cpu_cond_codes,
  output logic stack_push,
  output logic [7:0] stack_byte,
  output logic set_i_mask,
  output logic handler_valid,
  output logic [15:0] handler_addr
);
  import epiv_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Lowest set bit wins: lower number, higher priority
  function automatic logic [4:0] lowest_set(input logic [EPIV_NUM_VEC-1:0] v);
    logic [4:0] r;
    r = 5'h1f;
    for (int i = EPIV_NUM_VEC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // Vector 31 sits at the table base, so the index is the inverted number
  function automatic logic [5:0] vec_index(input logic [4:0] vec, input logic low);
    return {~vec, low};
  endfunction

  epiv_vec_if vbus ();

  epiv_vec_mem #(
    .DEPTH(64)
  ) u_mem (
    .clk(clk),
    .bus(vbus)
  );

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  logic pin_enable;
  logic polarity;
  logic mode_level;
  logic pull_off;
  logic pin_irq_en;
  logic flag;
  logic sync1;
  logic sync2;
  logic prev_asserted;

  wire apb_write = psel && penable && pwrite && pready;
  wire sel_ctrl = (paddr == EPIV_REG_PIN_CTRL);
  wire sel_pend = (paddr == EPIV_REG_PENDING);
  wire sel_win = (paddr == EPIV_REG_WINNER);
  wire sel_vec = (paddr >= EPIV_REG_VEC_BASE) && (paddr <= EPIV_REG_VEC_LAST)
    && (paddr[1:0] == 2'b00);
  wire mapped = sel_ctrl || sel_pend || sel_win || sel_vec;
  wire ctrl_wr = apb_write && sel_ctrl;
  wire ack_wr = ctrl_wr && pwdata[EPIV_BIT_ACK];

  // Reset leaves the pin function off with the internal pull selected
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {pull_off, pin_irq_en, mode_level, polarity, pin_enable} <= EPIV_CTRL_RESET;
    end else if (ctrl_wr) begin
      pin_enable <= pwdata[EPIV_BIT_ENABLE];
      polarity <= pwdata[EPIV_BIT_POLARITY];
      mode_level <= pwdata[EPIV_BIT_MODE];
      pull_off <= pwdata[EPIV_BIT_PULL_OFF];
      pin_irq_en <= pwdata[EPIV_BIT_IRQ_EN];
    end
  end

  // ----------------------------------------------------------------------
  // Pin sampling and event detection
  // ----------------------------------------------------------------------
  // Two stages before any logic except the stop-mode wake looks at the pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
    end
  end

  // Polarity 1 means rising edges and high levels count
  wire asserted = polarity ? sync2 : ~sync2;
  wire pin_edge = pin_enable && asserted && !prev_asserted;
  wire pin_level_hit = pin_enable && mode_level && asserted;
  wire pin_event = pin_edge || pin_level_hit;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_asserted <= 1'b0;
    end else begin
      prev_asserted <= asserted;
    end
  end

  // New events win over an acknowledge in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (pin_event) begin
      flag <= 1'b1;
    end else if (ack_wr) begin
      flag <= 1'b0;
    end
  end

  // Pull follows polarity: pullup for falling/low, pulldown for rising/high
  assign pull_up_en = pin_enable && !pull_off && !polarity;
  assign pull_down_en = pin_enable && !pull_off && polarity;

  // Stop mode has no clock, so the raw pin is gated directly
  wire raw_asserted = polarity ? pin_in : ~pin_in;
  assign wake_req = stop_mode && pin_enable && raw_asserted;

  assign branch_pin_level = sync2;
  assign branch_pin_valid = pin_enable;

  // ----------------------------------------------------------------------
  // Request gathering and priority
  // ----------------------------------------------------------------------
  logic [EPIV_NUM_VEC-1:0] pending;
  logic [EPIV_NUM_VEC-1:0] user_mask;

  // Unused user vectors are tied off whatever arrives on src_req
  generate
    for (genvar g = 0; g < EPIV_NUM_VEC; g++) begin : g_req
      if (g >= EPIV_USER_VEC_LO) begin : g_free
        assign user_mask[g] = 1'b0;
        assign pending[g] = 1'b0;
      end else if (g == EPIV_PIN_VECTOR) begin : g_pin
        assign user_mask[g] = 1'b1;
        assign pending[g] = flag && pin_irq_en;
      end else begin : g_src
        assign user_mask[g] = 1'b1;
        assign pending[g] = src_req[g];
      end
    end
  endgenerate

  wire [4:0] winner = lowest_set(pending);
  assign irq_to_cpu = |pending;

  // ----------------------------------------------------------------------
  // Interrupt sequencer
  // ----------------------------------------------------------------------
  epiv_seq_e state;
  epiv_seq_e next_state;
  logic [2:0] push_cnt;
  logic [4:0] vec_sel;
  logic [7:0] hi_byte;
  logic [39:0] frame;
  logic apb_rd_valid;

  wire apb_vec_busy = psel && sel_vec;
  wire seq_start = (state == EPIV_ST_IDLE) && cpu_boundary && irq_to_cpu
    && !cpu_i_mask && !apb_vec_busy;
  wire push_last = (push_cnt == EPIV_STACK_LAST);

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      EPIV_ST_IDLE: begin
        if (seq_start) begin
          next_state = EPIV_ST_PUSH;
        end
      end
      EPIV_ST_PUSH: begin
        if (push_last) begin
          next_state = EPIV_ST_FETCH_HI;
        end
      end
      EPIV_ST_FETCH_HI: next_state = EPIV_ST_FETCH_LO;
      EPIV_ST_FETCH_LO: next_state = EPIV_ST_DONE;
      EPIV_ST_DONE: next_state = EPIV_ST_IDLE;
      default: next_state = EPIV_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= EPIV_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Capture the CPU registers once so the frame is consistent
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame <= '0;
      push_cnt <= '0;
    end else if (seq_start) begin
      frame <= {cpu_pc[7:0], cpu_pc[15:8], cpu_x, cpu_a, cpu_cond_codes};
      push_cnt <= '0;
    end else if (state == EPIV_ST_PUSH) begin
      frame <= {frame[31:0], 8'h00};
      push_cnt <= push_cnt + 3'h1;
    end
  end

  assign stack_push = (state == EPIV_ST_PUSH);
  assign stack_byte = frame[39:32];
  assign set_i_mask = (state == EPIV_ST_PUSH) && push_last;

  // Winner chosen after stacking, so a later higher source is honoured
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vec_sel <= '0;
    end else if ((state == EPIV_ST_PUSH) && push_last) begin
      vec_sel <= winner;
    end
  end

  // High byte first at the even index, low byte at the next
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hi_byte <= '0;
      handler_addr <= '0;
    end else if (state == EPIV_ST_FETCH_LO) begin
      hi_byte <= vbus.rd_data;
    end else if (state == EPIV_ST_DONE) begin
      handler_addr <= {hi_byte, vbus.rd_data};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      handler_valid <= 1'b0;
    end else begin
      handler_valid <= (state == EPIV_ST_DONE);
    end
  end

  // ----------------------------------------------------------------------
  // Vector memory access
  // ----------------------------------------------------------------------
  wire seq_owns = (state == EPIV_ST_FETCH_HI) || (state == EPIV_ST_FETCH_LO);
  wire [5:0] apb_index = paddr[7:2];
  wire apb_issue = apb_vec_busy && !pwrite && !seq_owns && !apb_rd_valid;

  assign vbus.rd_addr = (state == EPIV_ST_FETCH_HI) ? vec_index(vec_sel, 1'b0) :
    (state == EPIV_ST_FETCH_LO) ? vec_index(vec_sel, 1'b1) : apb_index;
  assign vbus.wr_en = apb_write && sel_vec;
  assign vbus.wr_addr = apb_index;
  assign vbus.wr_data = pwdata[7:0];

  // Read data is one cycle behind the address, so vector reads wait for it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      apb_rd_valid <= 1'b0;
    end else begin
      apb_rd_valid <= apb_issue;
    end
  end

  // ----------------------------------------------------------------------
  // APB read side
  // ----------------------------------------------------------------------
  logic [31:0] reg_rdata;

  wire [7:0] ctrl_view = {sync2, flag, 1'b0, pin_irq_en, pull_off, mode_level, polarity,
    pin_enable};
  wire [31:0] next_rdata = sel_ctrl ? {24'h000000, ctrl_view} :
    sel_pend ? pending :
    sel_win ? {27'h0000000, winner} : 32'h00000000;

  // Sampled in the setup cycle, stable through the access phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (psel && !penable) begin
      reg_rdata <= next_rdata;
    end
  end

  assign pready = !(sel_vec && !pwrite) || apb_rd_valid;
  assign prdata = sel_vec ? {24'h000000, vbus.rd_data} : reg_rdata;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_flag_on_edge: assert property (pin_edge |=> flag)
    else $error("Flag not set after pin edge");
  a_level_hold: assert property (pin_level_hit && ack_wr |=> flag)
    else $error("Level mode flag cleared while pin asserted");
  a_edge_only_hold: assert property (flag && !mode_level && !ack_wr |=> flag)
    else $error("Edge-only flag dropped without acknowledge");
  a_disabled_quiet: assert property (!pin_enable |-> !pin_event && !wake_req)
    else $error("Pin event while pin disabled");
  a_pull_select: assert property ((pull_up_en || pull_down_en) |-> pin_enable && !pull_off
    && (pull_down_en == polarity))
    else $error("Pull device does not match polarity");
  a_pull_off: assert property (pull_off |-> !pull_up_en && !pull_down_en)
    else $error("Internal pull on while disabled");
  a_pin_gate: assert property (flag && !pin_irq_en |-> !pending[EPIV_PIN_VECTOR])
    else $error("Pin request without interrupt enable");
  a_user_free: assert property ((pending & ~user_mask) == 32'h00000000)
    else $error("Request on a free user vector");
  a_prio_pick: assert property (irq_to_cpu |-> pending[winner]
    && ((pending & ((32'h00000001 << winner) - 32'h00000001)) == 32'h00000000))
    else $error("Winner is not the lowest pending vector");
  a_masked_wait: assert property ((state == EPIV_ST_IDLE) && cpu_i_mask
    |=> state == EPIV_ST_IDLE)
    else $error("Sequence started while masked");
  a_push_frame: assert property (seq_start |=> stack_push [*5] ##1 !stack_push
    ##3 handler_valid)
    else $error("Stacking or vector fetch out of step");

endmodule

// ==== bench/epiv_cpu_model.sv ====
// CPU core stand-in: ends an instruction every other cycle, owns the global mask,
// and records the stacked frame and the handler address it is sent to.
// Assumes the request block sequences on the same clock.
`timescale 1ns/1ps
module epiv_cpu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mask_clear,
  input wire logic stack_push,
  input wire logic [7:0] stack_byte,
  input wire logic set_i_mask,
  input wire logic handler_valid,
  input wire logic [15:0] handler_addr,
  output logic cpu_boundary,
  output logic cpu_i_mask,
  output logic [15:0] cpu_pc,
  output logic [7:0] cpu_x,
  output logic [7:0] cpu_a,
  output logic [7:0] cpu_cond_codes,
  output logic [39:0] frame,
  output logic [15:0] last_handler,
  output logic [7:0] seq_count
);
  // Fixed register contents keep the stacked frame predictable
  assign cpu_pc = 16'h1234;
  assign cpu_x = 8'h56;
  assign cpu_a = 8'h78;
  assign cpu_cond_codes = 8'h9a;

  // Mask starts set, as after a real reset; only the bench clears it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_boundary <= 1'h0;
      cpu_i_mask <= 1'h1;
      frame <= '0;
      last_handler <= '0;
      seq_count <= '0;
    end else begin
      cpu_boundary <= ~cpu_boundary; // Two-cycle instructions
      if (set_i_mask) begin
        cpu_i_mask <= 1'h1;
      end else if (mask_clear) begin
        cpu_i_mask <= 1'h0;
      end
      if (stack_push) begin
        frame <= {frame[31:0], stack_byte};
      end
      if (handler_valid) begin
        last_handler <= handler_addr;
        seq_count <= seq_count + 8'h01;
      end
    end
  end
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the pin request and vectoring block.
// Assumes the CPU stand-in model; the pin is driven straight from here.
`timescale 1ns/1ps
module tb;
  import epiv_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pin_in, stop_mode, mask_clear, err;
  logic pready, pslverr, pull_up_en, pull_down_en, wake_req, branch_pin_level;
  logic branch_pin_valid, irq_to_cpu, cpu_boundary, cpu_i_mask, stack_push;
  logic set_i_mask, handler_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, src_req, rd;
  logic [15:0] cpu_pc, handler_addr, last_handler;
  logic [7:0] cpu_x, cpu_a, cpu_cond_codes, stack_byte, seq_count, seen_seq;
  logic [39:0] frame;
  int bad_count = 0;
  int total_checks = 0;
  // Row fields: control byte, pin, pull up, pull down, wake (with stop_mode high)
  logic [11:0] rows [7] = '{12'h015, 12'h01c, 12'h03b, 12'h0b9, 12'h091, 12'h028, 12'h000};

  epiv_top i_epiv_top (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .pin_in, .stop_mode, .pull_up_en, .pull_down_en, .wake_req,
    .branch_pin_level, .branch_pin_valid, .src_req, .irq_to_cpu, .cpu_boundary, .cpu_i_mask,
    .cpu_pc, .cpu_x, .cpu_a, .cpu_cond_codes, .stack_push, .stack_byte, .set_i_mask,
    .handler_valid, .handler_addr);
  epiv_cpu_model i_epiv_cpu_model (.clk, .rst_n, .mask_clear, .stack_push, .stack_byte,
    .set_i_mask, .handler_valid, .handler_addr, .cpu_boundary, .cpu_i_mask, .cpu_pc, .cpu_x,
    .cpu_a, .cpu_cond_codes, .frame, .last_handler, .seq_count);

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask

  // One APB transfer; the idle edge first keeps back-to-back calls race free
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    // Only the watchdog ends a wait for the answer
    while (pready !== 1'h1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic flag_is(input logic e);
    apb(1'h0, EPIV_REG_PIN_CTRL, 32'h0);
    check("flag", rd[6], e);
  endtask

  // Unmask and wait, bounded, for the model to see one handler jump
  task automatic run_seq();
    int k;
    k = 0;
    seen_seq = seq_count;
    mask_clear <= 1'h1;
    @(posedge clk);
    mask_clear <= 1'h0;
    while (seq_count === seen_seq && k < 40) begin
      k++;
      @(posedge clk);
    end
    if (k == 40) bad_count++;
  endtask

  initial begin
    repeat (4000) @(posedge clk);
    bad_count++;
    finish_test();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, stop_mode, mask_clear} = 6'h0;
    {paddr, pwdata, src_req} = '0;
    pin_in = 1'h1;
    cyc(5);
    rst_n <= 1'h1;
    apb(1'h0, EPIV_REG_PIN_CTRL, 32'h0);
    check("ctrl_rst", rd[6:0], 40'h0);
    check("pulls_rst", {pull_up_en, pull_down_en}, 40'h0);
    apb(1'h0, EPIV_REG_WINNER, 32'h0);
    check("winner_idle", rd, 40'h1f);
    apb(1'h0, 12'h00c, 32'h0);
    check("unmapped", {err, rd}, 40'h100000000);
    stop_mode <= 1'h1;
    foreach (rows[i]) begin
      pin_in <= rows[i][3];
      apb(1'h1, EPIV_REG_PIN_CTRL, {24'h0, rows[i][11:4]});
      cyc(3);
      check("pulls", {pull_up_en, pull_down_en}, rows[i][2:1]);
      check("wake", wake_req, rows[i][0]);
      check("br_valid", branch_pin_valid, rows[i][4]);
      if (rows[i][4]) check("br_level", branch_pin_level, rows[i][3]);
    end
    // Edge-only, falling, interrupt on; then interrupt off
    stop_mode <= 1'h0;
    pin_in <= 1'h1;
    apb(1'h1, EPIV_REG_PIN_CTRL, 32'h21);
    apb(1'h1, EPIV_REG_PIN_CTRL, 32'h11);
    pin_in <= 1'h0;
    cyc(4);
    flag_is(1'h1);
    check("irq_on", irq_to_cpu, 40'h1);
    pin_in <= 1'h1;
    cyc(4);
    flag_is(1'h1);
    apb(1'h1, EPIV_REG_PIN_CTRL, 32'h31);
    flag_is(1'h0);
    check("irq_off", irq_to_cpu, 40'h0);
    apb(1'h1, EPIV_REG_PIN_CTRL, 32'h01);
    pin_in <= 1'h0;
    cyc(4);
    flag_is(1'h1);
    check("irq_gated", irq_to_cpu, 40'h0);
    // Level mode, rising: acknowledge refused while the pin stays high
    apb(1'h1, EPIV_REG_PIN_CTRL, 32'h06);
    apb(1'h1, EPIV_REG_PIN_CTRL, 32'h27);
    flag_is(1'h0);
    pin_in <= 1'h1;
    cyc(4);
    apb(1'h1, EPIV_REG_PIN_CTRL, 32'h27);
    flag_is(1'h1);
    pin_in <= 1'h0;
    cyc(4);
    apb(1'h1, EPIV_REG_PIN_CTRL, 32'h27);
    flag_is(1'h0);
    // Edge-only, rising: acknowledge works although the pin is still high
    apb(1'h1, EPIV_REG_PIN_CTRL, 32'h03);
    pin_in <= 1'h1;
    cyc(4);
    flag_is(1'h1);
    apb(1'h1, EPIV_REG_PIN_CTRL, 32'h23);
    flag_is(1'h0);
    // Disabled pin ignores edges
    apb(1'h1, EPIV_REG_PIN_CTRL, 32'h02);
    pin_in <= 1'h0;
    cyc(4);
    pin_in <= 1'h1;
    cyc(4);
    flag_is(1'h0);
    // Vectors 2 and 3 get handler 16'hc000 plus the vector number
    for (int v = 2; v < 4; v++) begin
      apb(1'h1, EPIV_REG_VEC_BASE + 12'(8 * (31 - v)), 32'hc0);
      apb(1'h1, EPIV_REG_VEC_BASE + 12'(8 * (31 - v) + 4), 32'(v));
    end
    apb(1'h0, EPIV_REG_VEC_BASE + 12'h0ec, 32'h0);
    check("table", rd, 40'h2);
    pin_in <= 1'h0;
    apb(1'h1, EPIV_REG_PIN_CTRL, 32'h13);
    pin_in <= 1'h1;
    src_req <= 32'h10000004;
    cyc(4);
    apb(1'h0, EPIV_REG_PENDING, 32'h0);
    check("pending", rd, 40'hc);
    apb(1'h0, EPIV_REG_WINNER, 32'h0);
    check("winner", rd, 40'h2);
    run_seq();
    check("frame", frame, 40'h3412_5678_9a);
    check("handler", last_handler, 40'hc002);
    check("mask_set", cpu_i_mask, 40'h1);
    cyc(20);
    check("masked_idle", seq_count, seen_seq + 8'h01);
    src_req <= 32'h0;
    run_seq();
    check("handler_next", last_handler, 40'hc003);
    apb(1'h1, EPIV_REG_PIN_CTRL, 32'h33);
    cyc(1);
    check("irq_ack", irq_to_cpu, 40'h0);
    // Reset in mid-run with everything enabled
    apb(1'h1, EPIV_REG_PIN_CTRL, 32'h17);
    rst_n <= 1'h0;
    cyc(2);
    rst_n <= 1'h1;
    apb(1'h0, EPIV_REG_PIN_CTRL, 32'h0);
    check("ctrl_rst2", rd[6:0], 40'h0);
    check("pulls_rst2", {pull_up_en, pull_down_en, branch_pin_valid}, 40'h0);
    finish_test();
  end
endmodule
